//--- design/pwm_input_capture_control.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pwm_capture_consts.svh"
// Operation
// - six capture channels, each with its own bit in every per-channel field, enable at bit n.
// - with its enable at 0 a channel never updates its rising or falling capture value.
// - with its enable at 1 a rising input edge latches the counter into the rising value.
// - with its enable at 1 a falling input edge latches the counter into the falling value.
// - the invert bit at n+8 inverts the pin input ahead of edge detection when set.
// - the rising reload bit at n+16 lets a rising capture reload the channel counter.
// - the falling reload bit at n+24 lets a falling capture reload the channel counter.
// - the rising overrun bit n sets when a rising latch meets a rising flag already set.
// - the falling overrun bit n+8 sets when a falling latch meets a falling flag already set.
// - the rising overrun bit clears itself when software clears the rising flag.
// - the falling overrun bit clears itself when software clears the falling flag.
// - the status word is read-only and both control and status reset to zero.
// - with its input path disabled a channel sees a constant 0 in place of the pin, ahead of its invert bit.
module pwm_input_capture_control
  import pwm_capture_pkg::*;
#(
  parameter int COUNTER_WIDTH = `COUNTER_WIDTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`CHANNELS-1:0] capture_pin,
  input wire logic [`CHANNELS-1:0][COUNTER_WIDTH-1:0] counter_value,
  output logic [`CHANNELS-1:0] counter_reload
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  capture_control_type capture_control;
  edge_pair_type capture_overrun_status;
  edge_pair_type capture_irq_flags;
  logic [`CHANNELS-1:0] input_path_en;
  logic [`CHANNELS-1:0][COUNTER_WIDTH-1:0] rise_capture_value;
  logic [`CHANNELS-1:0][COUNTER_WIDTH-1:0] fall_capture_value;

  // ----------------------------------------
  // address decode shared by both bus directions
  // ----------------------------------------
  function automatic reg_sel_type decode_sel(input logic [`ADDR_WIDTH-1:0] addr);
    logic [`ADDR_WIDTH-1:0] offset;
    offset = addr - `ADDR_CAPTURE_VALUE_BASE;
    if (addr[1:0] != 2'h0) begin
      decode_sel = sel_none;
    end else if (addr == `ADDR_INPUT_PATH_EN) begin
      decode_sel = sel_path;
    end else if (addr == `ADDR_CAPTURE_CONTROL) begin
      decode_sel = sel_control;
    end else if (addr == `ADDR_CAPTURE_OVERRUN_STATUS) begin
      decode_sel = sel_status;
    end else if (addr == `ADDR_CAPTURE_IRQ_FLAGS) begin
      decode_sel = sel_flags;
    end else if (addr >= `ADDR_CAPTURE_VALUE_BASE && addr <= `ADDR_CAPTURE_VALUE_LAST) begin
      decode_sel = offset[2] ? sel_fall_value : sel_rise_value;
    end else begin
      decode_sel = sel_none;
    end
  endfunction

  function automatic logic [2:0] decode_channel(input logic [`ADDR_WIDTH-1:0] addr);
    logic [`ADDR_WIDTH-1:0] offset;
    offset = addr - `ADDR_CAPTURE_VALUE_BASE;
    decode_channel = offset[5:3];
  endfunction

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [`ADDR_WIDTH-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic write_fire;
  reg_sel_type write_sel;
  logic [31:0] write_mask;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign write_fire = aw_held && w_held && !s_axi_bvalid;
  assign write_sel = decode_sel(aw_addr);
  assign write_mask = strobe_mask(w_strb);

  // address and data are taken in either order and held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= `RESET_WORD;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (write_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (write_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (write_sel == sel_none) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_control <= `RESET_WORD;
      input_path_en <= '0;
    end else if (write_fire) begin
      if (write_sel == sel_control) begin
        capture_control <= (capture_control & ~write_mask) | (w_data & write_mask);
        capture_control.reserved_hi <= 2'h0;
        capture_control.reserved_b <= 2'h0;
        capture_control.reserved_a <= 2'h0;
        capture_control.reserved_lo <= 2'h0;
      end else if (write_sel == sel_path) begin
        input_path_en <= (input_path_en & ~write_mask[5:0]) | (w_data[5:0] & write_mask[5:0]);
      end
    end
  end

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  logic [`CHANNELS-1:0] capture_source;
  logic [`CHANNELS-1:0] capture_last;
  logic [`CHANNELS-1:0] rise_latch;
  logic [`CHANNELS-1:0] fall_latch;

  // path gate first, inverter after it, so an idle disabled path reads as 0 ^ invert
  assign capture_source = (capture_pin & input_path_en)
                          ^ capture_control.input_invert_en;
  assign rise_latch = capture_source & ~capture_last & capture_control.capture_fn_en;
  assign fall_latch = ~capture_source & capture_last & capture_control.capture_fn_en;

  // the previous level follows even while disabled, so enabling never fakes an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_last <= '0;
    end else begin
      capture_last <= capture_source;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_capture_value <= '0;
      fall_capture_value <= '0;
    end else begin
      for (int ch = 0; ch < `CHANNELS; ch++) begin
        if (rise_latch[ch]) begin
          rise_capture_value[ch] <= counter_value[ch];
        end
        if (fall_latch[ch]) begin
          fall_capture_value[ch] <= counter_value[ch];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_reload <= '0;
    end else begin
      counter_reload <= (rise_latch & capture_control.rise_reload_en)
                        | (fall_latch & capture_control.fall_reload_en);
    end
  end

  // ----------------------------------------
  // latch flags and overrun status
  // ----------------------------------------
  logic [`CHANNELS-1:0] rise_clear;
  logic [`CHANNELS-1:0] fall_clear;

  // write one to clear; a latch in the same cycle wins over the clear
  assign rise_clear = (write_fire && write_sel == sel_flags) ?
                      (w_data[5:0] & write_mask[5:0]) : '0;
  assign fall_clear = (write_fire && write_sel == sel_flags) ?
                      (w_data[13:8] & write_mask[13:8]) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_irq_flags <= `RESET_WORD;
    end else begin
      capture_irq_flags.rise <= (capture_irq_flags.rise & ~rise_clear) | rise_latch;
      capture_irq_flags.fall <= (capture_irq_flags.fall & ~fall_clear) | fall_latch;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_overrun_status <= `RESET_WORD;
    end else begin
      capture_overrun_status.rise <=
        (capture_overrun_status.rise & ~(rise_clear & ~rise_latch))
        | (rise_latch & capture_irq_flags.rise);
      capture_overrun_status.fall <=
        (capture_overrun_status.fall & ~(fall_clear & ~fall_latch))
        | (fall_latch & capture_irq_flags.fall);
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg_sel_type read_sel;
  logic [2:0] read_channel;
  logic [31:0] read_word;

  assign s_axi_arready = !s_axi_rvalid;
  assign read_sel = decode_sel(s_axi_araddr);
  assign read_channel = decode_channel(s_axi_araddr);

  always_comb begin
    read_word = `RESET_WORD;
    case (read_sel)
      sel_path: read_word[5:0] = input_path_en;
      sel_control: read_word = capture_control;
      sel_status: read_word = capture_overrun_status;
      sel_flags: read_word = capture_irq_flags;
      sel_rise_value: read_word[COUNTER_WIDTH-1:0] = rise_capture_value[read_channel];
      sel_fall_value: read_word[COUNTER_WIDTH-1:0] = fall_capture_value[read_channel];
      default: read_word = `RESET_WORD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RESET_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= (read_sel == sel_none) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- pkg/pwm_capture_consts.svh
`ifndef PWM_CAPTURE_CONSTS_SVH
`define PWM_CAPTURE_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_INPUT_PATH_EN 12'h200
`define ADDR_CAPTURE_CONTROL 12'h204
`define ADDR_CAPTURE_OVERRUN_STATUS 12'h208
`define ADDR_CAPTURE_VALUE_BASE 12'h20c
`define ADDR_CAPTURE_VALUE_LAST 12'h238
`define ADDR_CAPTURE_IRQ_FLAGS 12'h250

// ----------------------------------------
// field positions and sizes
// ----------------------------------------
`define CHANNELS 6
`define RISE_FIELD_LSB 0
`define FALL_FIELD_LSB 8
`define ADDR_WIDTH 12
`define COUNTER_WIDTH 16

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define RESET_WORD 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- pkg/pwm_capture_pkg.sv
package pwm_capture_pkg;

  // layout of the capture control word
  typedef struct packed {
    logic [1:0] reserved_hi;
    logic [5:0] fall_reload_en;
    logic [1:0] reserved_b;
    logic [5:0] rise_reload_en;
    logic [1:0] reserved_a;
    logic [5:0] input_invert_en;
    logic [1:0] reserved_lo;
    logic [5:0] capture_fn_en;
  } capture_control_type;

  // rising and falling per-channel flag pair, shared by status and flag words
  typedef struct packed {
    logic [17:0] reserved_hi;
    logic [5:0] fall;
    logic [1:0] reserved_lo;
    logic [5:0] rise;
  } edge_pair_type;

  typedef enum logic [2:0] {
    sel_none,
    sel_path,
    sel_control,
    sel_status,
    sel_flags,
    sel_rise_value,
    sel_fall_value
  } reg_sel_type;

endpackage

//--- verification/capture_pin_source.sv
`timescale 1ns/1ps
module capture_pin_source (
  input wire logic aclk,
  input wire logic [5:0] level,
  output logic [5:0] capture_pin
);
  // a pin changes only on the sampling edge: one stage delays level by one cycle
  always_ff @(posedge aclk) begin
    capture_pin <= level;
  end
endmodule

//--- verification/capture_bus_properties.sv
`timescale 1ns/1ps
`include "pwm_capture_consts.svh"
module capture_bus_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] counter_reload
);
  // ----------------------------------------
  // bus answers and reset state
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  // both halves are held for one cycle before the register write and the answer
  write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("no write response");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  bad_write_a: assert property (wr_take && s_axi_awaddr[1:0] != 2'h0
    |-> ##2 s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)
    else $error("misaligned write not refused");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("no read response");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  bad_read_a: assert property (rd_take && s_axi_araddr > `ADDR_CAPTURE_IRQ_FLAGS
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && counter_reload == 6'h0) else $error("reset state wrong");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (counter_reload != 6'h0);
endmodule
bind pwm_input_capture_control capture_bus_properties u_props (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .counter_reload
);

//--- verification/testbench.sv
`timescale 1ns/1ps
`include "pwm_capture_consts.svh"
module testbench;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  wire awr, wr_rdy, bv, arr, rv_o;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] pin, reload;
  logic [5:0][15:0] count = '0;
  logic [5:0] level = 0, rf = 0, ff = 0, ro = 0, fo = 0, path = 0, en = 0, inv = 0;
  logic [5:0] rre = 0, fre = 0, src_old = 0;
  logic [15:0] rv[6] = '{default: 16'h0}, fv[6] = '{default: 16'h0};
  logic [33:0] exp_q[$];
  string name_q[$];
  int n_errors = 0, checked = 0;
  capture_pin_source u_src (.aclk(aclk), .level(level), .capture_pin(pin));
  pwm_input_capture_control u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv_o), .s_axi_rready(rr), .capture_pin(pin), .counter_value(count),
    .counter_reload(reload));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  initial forever #10 aclk = ~aclk;
  task automatic check(string nm, logic [33:0] e, logic [33:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // answers are sampled mid-cycle, where the handshake edge has not yet moved them
  always @(negedge aclk) begin
    if (bv && br) check(name_q.pop_front(), exp_q.pop_front(), {bresp, 32'h0});
    if (rv_o && rr) check(name_q.pop_front(), exp_q.pop_front(), {rresp, rdata});
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    finish_test();
  end
  // ----------------------------------------
  // bus master and capture model
  // ----------------------------------------
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r = `RESP_OKAY);
    logic da, dw;
    da = 0;
    dw = 0;
    exp_q.push_back({r, 32'h0});
    name_q.push_back($sformatf("bresp %h", a));
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    do begin
      @(negedge aclk);
      da |= awv && awr;
      dw |= wv && wr_rdy;
      @(posedge aclk);
      if (da) awv <= 0;
      if (dw) wv <= 0;
    end while (!(da && dw));
    repeat ($urandom % 3) @(posedge aclk);
    br <= 1;
    do @(negedge aclk); while (!bv);
    @(posedge aclk);
    br <= 0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r = `RESP_OKAY);
    exp_q.push_back({r, d});
    name_q.push_back($sformatf("read %h", a));
    @(posedge aclk);
    ara <= a; arv <= 1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 0;
    repeat ($urandom % 3) @(posedge aclk);
    rr <= 1;
    do @(negedge aclk); while (!rv_o);
    @(posedge aclk);
    rr <= 0;
  endtask
  function automatic logic [5:0] model();
    logic [5:0] s;
    model = 0;
    s = (level & path) ^ inv;
    for (int i = 0; i < 6; i++)
      if (en[i] && s[i] != src_old[i]) begin
        if (s[i]) begin
          ro[i] |= rf[i]; rf[i] = 1; rv[i] = count[i]; model[i] = rre[i];
        end else begin
          fo[i] |= ff[i]; ff[i] = 1; fv[i] = count[i]; model[i] = fre[i];
        end
      end
    src_old = s;
  endfunction
  task automatic ctl();
    wr(`ADDR_CAPTURE_CONTROL, {2'h0, fre, 2'h0, rre, 2'h0, inv, 2'h0, en});
    void'(model());
    rd(`ADDR_CAPTURE_CONTROL, {2'h0, fre, 2'h0, rre, 2'h0, inv, 2'h0, en});
  endtask
  task automatic pins(logic [5:0] lv);
    logic [5:0] seen, e;
    seen = 0;
    @(posedge aclk);
    level <= lv;
    for (int i = 0; i < 6; i++) count[i] <= 16'($urandom);
    @(negedge aclk);
    e = model();
    repeat (6) begin
      @(negedge aclk);
      seen |= reload;
    end
    check("counter_reload", {28'h0, e}, {28'h0, seen});
  endtask
  initial begin
    void'($urandom(32'h2f39));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(`ADDR_CAPTURE_CONTROL, `RESET_WORD);
    wr(`ADDR_CAPTURE_OVERRUN_STATUS, 32'h3f3f);
    rd(`ADDR_CAPTURE_OVERRUN_STATUS, `RESET_WORD);
    wr(12'h205, 32'h1, `RESP_SLVERR);
    rd(12'h300, 32'h0, `RESP_SLVERR);
    $display("test registers done");
    path = 6'h1f;
    wr(`ADDR_INPUT_PATH_EN, {26'h0, path});
    // invert set while disabled so its level change is not taken as an edge
    inv = 6'h02;
    ctl();
    en = 6'h2f; rre = 6'h01; fre = 6'h04;
    ctl();
    pins(6'h3f);
    pins(6'h00);
    pins(6'h3f);
    pins(6'h00);
    repeat (4) pins(6'($urandom));
    for (int i = 0; i < 6; i++) begin
      rd(12'h20c + 12'(8 * i), {16'h0, rv[i]});
      rd(12'h210 + 12'(8 * i), {16'h0, fv[i]});
    end
    $display("test capture done");
    rd(`ADDR_CAPTURE_OVERRUN_STATUS, {18'h0, fo, 2'h0, ro});
    rd(`ADDR_CAPTURE_IRQ_FLAGS, {18'h0, ff, 2'h0, rf});
    wr(`ADDR_CAPTURE_IRQ_FLAGS, 32'h3f3f);
    rd(`ADDR_CAPTURE_OVERRUN_STATUS, `RESET_WORD);
    $display("test overrun clear done");
    finish_test();
  end
endmodule
